// ---- include/lsf_defs.svh ----
// Timing and field constants for the low-side switch fault timing block.
`ifndef LSF_DEFS_SVH
`define LSF_DEFS_SVH
`define LSF_CLK_MHZ            200
`define LSF_RETRY_WINDOW_US    50
`define LSF_RETRY_CYC          (`LSF_RETRY_WINDOW_US * `LSF_CLK_MHZ)
`define LSF_REFRESH_WAIT_US    4500
`define LSF_REFRESH_CYC        (`LSF_REFRESH_WAIT_US * `LSF_CLK_MHZ)
`define LSF_OFF_SENSE_US       60
`define LSF_OFF_SENSE_CYC      (`LSF_OFF_SENSE_US * `LSF_CLK_MHZ)
`define LSF_ON_SENSE_US        6000
`define LSF_ON_SENSE_CYC       (`LSF_ON_SENSE_US * `LSF_CLK_MHZ)
`define LSF_CHANNELS           6
`define LSF_OL_EN_LO_BIT       6
`define LSF_OL_EN_HI_BIT       7
`define LSF_FRAME_BITS         16
`define LSF_STATUS_BITS        8
`define LSF_CNT_W              24
`endif

// ---- include/lsf_pkg.sv ----
// Types shared by the low-side switch fault timing block.
package lsf_pkg;
  typedef struct packed {
    logic [5:0] short_fault;
    logic [5:0] open_fault;
  } lsf_sense_type;

  typedef enum logic [2:0] {
    LSF_NORMAL  = 3'b001,
    LSF_RETRY   = 3'b010,
    LSF_REFRESH = 3'b100
  } lsf_short_state_type;
endpackage : lsf_pkg

// ---- logic/lsf_switch.sv ----
// Serial status port and fault timing of a six-channel low-side switch.
// Function
// - A shorted output retries in current limit for the retry window, 25 to 100 us.
// - Between retries the shorted output stays off 3.0 to 6.0 ms.
// - Off-state open-load bit is ready no later than 100 us after turn-off.
// - On-state open-load bit is ready 3.0 to 12 ms after turn-on.
// - Serial commands reach the outputs only when chip select rises.
// - Serial output is driven only while chip select is low.
// - Serial output changes after each falling serial clock edge.
// - Commands 8 or 16 bits MSB first; low six switch channels, two enable on-sense.
`timescale 1ns/1ps
`include "lsf_defs.svh"
module lsf_switch #(
  parameter int RETRY_CYC   = `LSF_RETRY_CYC,
  parameter int REFRESH_CYC = `LSF_REFRESH_CYC,
  parameter int OFF_CYC     = `LSF_OFF_SENSE_CYC,
  parameter int ON_CYC      = `LSF_ON_SENSE_CYC
) (
  // System clock and reset.
  input  wire logic                   i_clk,
  input  wire logic                   i_reset_n,
  // Serial link, clocked by the host.
  input  wire logic                   i_sclk,
  input  wire logic                   i_cs_n,
  input  wire logic                   i_si,
  output logic                        o_so,
  output logic                        o_so_oe,
  // Load sensing from the power stage.
  input  wire lsf_pkg::lsf_sense_type i_sense,
  // Power switch gates, high turns a channel on.
  output logic [5:0]                  o_power_switch_outputs
);
  import lsf_pkg::*;

  // ------------------------------------------------------------
  // Link domain: shift register on the serial clock.
  // ------------------------------------------------------------
  // Capture happens at the first rising edge; the SO bit changes on falling edges.
  logic [15:0] shift_q;
  logic [15:0] shift_d;
  logic [4:0]  cnt_q;
  logic [4:0]  cnt_d;
  logic        so_q;
  logic [7:0]  fault_q;

  always_comb begin
    shift_d = shift_q;
    cnt_d   = cnt_q;
    if (cnt_q == 5'h00) begin
      shift_d = {fault_q, 7'h00, i_si};
    end else begin
      shift_d = {shift_q[14:0], i_si};
    end
    if (cnt_q != 5'h1F) begin
      cnt_d = cnt_q + 5'h01;
    end
  end

  // The counter is cleared asynchronously by chip select high so that each frame restarts.
  always_ff @(posedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      shift_q <= 16'h0000;
      cnt_q   <= 5'h00;
    end else begin
      shift_q <= shift_d;
      cnt_q   <= cnt_d;
    end
  end

  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      so_q <= 1'b0;
    end else begin
      so_q <= (cnt_q <= 5'(`LSF_STATUS_BITS)) ? shift_q[15] : 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Crossing from system domain: fault byte into link domain.
  // ------------------------------------------------------------
  // The fault register freezes a few system clocks after chip select falls, long before
  // the first serial rising edge, so the link logic reads it as a steady level.

  // ------------------------------------------------------------
  // System domain: synchronise chip select and latch commands.
  // ------------------------------------------------------------
  logic [2:0]  cs_sync_q;
  logic [2:0]  cs_sync_d;
  logic        cs_q;
  logic        cs_d;
  logic [15:0] frm_s1_q;
  logic [15:0] frm_s2_q;
  logic [15:0] frm_s3_q;
  logic [4:0]  cnt_s1_q;
  logic [4:0]  cnt_s2_q;
  logic [4:0]  cnt_s3_q;
  logic [7:0]  cmd_q;
  logic [7:0]  cmd_d;
  logic        cs_rise;
  logic        cs_fall;

  // Frame data is stable from the last serial clock rise until chip select rises, so multi-bit sampling is safe.
  always_ff @(posedge i_clk) begin
    frm_s1_q <= shift_q;
    frm_s2_q <= frm_s1_q;
    frm_s3_q <= frm_s2_q;
    cnt_s1_q <= cnt_q;
    cnt_s2_q <= cnt_s1_q;
    cnt_s3_q <= cnt_s2_q;
  end

  always_comb begin
    cs_sync_d = {cs_sync_q[1:0], i_cs_n};
    cs_d      = cs_q;
    if (cs_sync_q[2] == cs_sync_q[1]) begin
      cs_d = cs_sync_q[2];
    end
  end

  assign cs_rise = cs_d & ~cs_q;
  assign cs_fall = ~cs_d & cs_q;

  // Shift register clears on chip select high, so command is taken from the frame copy
  // seen just before the rise. Eight-bit frames land in the low byte either way.
  logic [15:0] last_frm_q;
  logic [4:0]  last_cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      last_frm_q <= 16'h0000;
      last_cnt_q <= 5'h00;
    end else if (!cs_q) begin
      last_frm_q <= frm_s3_q;
      last_cnt_q <= cnt_s3_q;
    end
  end

  always_comb begin
    cmd_d = cmd_q;
    if (cs_rise && (last_cnt_q == 5'h08 || last_cnt_q == 5'h10)) begin
      cmd_d = last_frm_q[7:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      cs_sync_q <= 3'b111;
      cs_q      <= 1'b1;
      cmd_q     <= 8'h00;
    end else begin
      cs_sync_q <= cs_sync_d;
      cs_q      <= cs_d;
      cmd_q     <= cmd_d;
    end
  end

  // SO enable follows raw chip select through a flip-flop in the link domain.
  always_ff @(negedge i_sclk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_so_oe <= 1'b0;
    end else begin
      o_so_oe <= 1'b1;
    end
  end
  // OE turns on at the first falling serial clock edge after chip select falls; SO is driven straight from so_q.
  assign o_so = so_q;

  // ------------------------------------------------------------
  // Per-channel fault timing.
  // ------------------------------------------------------------
  logic [2:0] sense_sync_q [0:11];
  logic [11:0] sense_s;
  logic [5:0]  gate_q;
  logic [7:0]  fault_d;
  logic        ol_on_en;
  assign ol_on_en = cmd_q[`LSF_OL_EN_LO_BIT] | cmd_q[`LSF_OL_EN_HI_BIT];

  genvar g;
  generate
    for (g = 0; g < 12; g++) begin : g_sync
      logic [2:0] s_d;
      logic       v_q;
      logic       v_d;
      logic [11:0] raw;
      assign raw = i_sense;
      always_comb begin
        s_d = {sense_sync_q[g][1:0], raw[g]};
        v_d = v_q;
        if (sense_sync_q[g][2] == sense_sync_q[g][1]) begin
          v_d = sense_sync_q[g][2];
        end
      end
      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          sense_sync_q[g] <= 3'b000;
          v_q             <= 1'b0;
        end else begin
          sense_sync_q[g] <= s_d;
          v_q             <= v_d;
        end
      end
      assign sense_s[g] = v_q;
    end

    for (g = 0; g < `LSF_CHANNELS; g++) begin : g_ch
      lsf_short_state_type st_q;
      lsf_short_state_type st_d;
      logic [`LSF_CNT_W-1:0] tmr_q;
      logic [`LSF_CNT_W-1:0] tmr_d;
      logic [`LSF_CNT_W-1:0] ol_q;
      logic [`LSF_CNT_W-1:0] ol_d;
      logic                  prev_q;
      logic                  olf_q;
      logic                  olf_d;
      logic                  gate_d;
      logic                  short_s;
      logic                  open_s;
      logic                  cmd_on;
      assign short_s = sense_s[g + 6];
      assign open_s  = sense_s[g];
      assign cmd_on  = cmd_q[g];

      always_comb begin
        st_d   = st_q;
        tmr_d  = tmr_q;
        gate_d = cmd_on;
        unique case (st_q)
          LSF_NORMAL: begin
            tmr_d = '0;
            if (cmd_on && short_s) begin
              st_d = LSF_RETRY;
            end
          end
          LSF_RETRY: begin
            tmr_d = tmr_q + 1'b1;
            if (!cmd_on) begin
              st_d = LSF_NORMAL;
            end else if (tmr_q == (`LSF_CNT_W)'(RETRY_CYC - 1)) begin
              tmr_d = '0;
              st_d  = short_s ? LSF_REFRESH : LSF_NORMAL;
            end
          end
          LSF_REFRESH: begin
            gate_d = 1'b0;
            tmr_d  = tmr_q + 1'b1;
            if (!cmd_on) begin
              st_d = LSF_NORMAL;
            end else if (tmr_q == (`LSF_CNT_W)'(REFRESH_CYC - 1)) begin
              tmr_d = '0;
              st_d  = LSF_RETRY;
            end
          end
        endcase
        // Open-load sensing time restarts on every change of the commanded switch state.
        ol_d  = (cmd_on != prev_q) ? '0 : ol_q + ((ol_q[`LSF_CNT_W-1]) ? 1'b0 : 1'b1);
        olf_d = olf_q;
        if (cmd_on != prev_q) begin
          olf_d = 1'b0;
        end else if (!cmd_on && ol_q >= (`LSF_CNT_W)'(OFF_CYC)) begin
          olf_d = open_s;
        end else if (cmd_on && ol_q >= (`LSF_CNT_W)'(ON_CYC) && ol_on_en) begin
          olf_d = open_s;
        end
      end

      always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
          st_q      <= LSF_NORMAL;
          tmr_q     <= '0;
          ol_q      <= '0;
          prev_q    <= 1'b0;
          olf_q     <= 1'b0;
          gate_q[g] <= 1'b0;
        end else begin
          st_q      <= st_d;
          tmr_q     <= tmr_d;
          ol_q      <= ol_d;
          prev_q    <= cmd_on;
          olf_q     <= olf_d;
          gate_q[g] <= gate_d;
        end
      end
      assign fault_d[g] = (st_q != LSF_NORMAL) | olf_q;
    end
  endgenerate
  assign fault_d[7:6] = 2'b00;

  // Fault register holds at chip select low so the captured byte stays coherent.
  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      fault_q <= 8'h00;
    end else if (cs_q) begin
      fault_q <= fault_d;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      o_power_switch_outputs <= 6'h00;
    end else begin
      o_power_switch_outputs <= gate_q;
    end
  end

  // ------------------------------------------------------------
  // Assertions.
  // ------------------------------------------------------------
  property p_cmd_on_rise;
    @(posedge i_clk) disable iff (!i_reset_n)
      !cs_rise |=> $stable(cmd_q);
  endproperty
  a_cmd_on_rise: assert property (p_cmd_on_rise) else $error("Command changed without chip select rise.");

  property p_refresh_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (g_ch[0].st_q == LSF_REFRESH) |=> !gate_q[0];
  endproperty
  a_refresh_off: assert property (p_refresh_off) else $error("Gate on during refresh.");

  property p_out_follows;
    @(posedge i_clk) disable iff (!i_reset_n)
      1'b1 |=> (o_power_switch_outputs == $past(gate_q));
  endproperty
  a_out_follows: assert property (p_out_follows) else $error("Outputs do not follow gates.");

  property p_so_quiet;
    @(posedge i_clk) disable iff (!i_reset_n)
      cs_q |-> !o_so_oe;
  endproperty
  a_so_quiet: assert property (p_so_quiet) else $error("Serial output driven with chip select high.");

  property p_retry_hold;
    @(posedge i_clk) disable iff (!i_reset_n)
      (g_ch[0].st_q == LSF_RETRY && g_ch[0].cmd_on && g_ch[0].tmr_q < (`LSF_CNT_W)'(RETRY_CYC - 1))
        |=> (g_ch[0].st_q == LSF_RETRY && gate_q[0]);
  endproperty
  a_retry_hold: assert property (p_retry_hold) else $error("Retry window ended early.");

  property p_off_sense;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!g_ch[0].cmd_on && !g_ch[0].prev_q && g_ch[0].ol_q >= (`LSF_CNT_W)'(OFF_CYC))
        |=> (g_ch[0].olf_q == $past(g_ch[0].open_s));
  endproperty
  a_off_sense: assert property (p_off_sense) else $error("Off-state open load not reported.");

  c_retry: cover property (@(posedge i_clk) g_ch[0].st_q == LSF_RETRY);
  c_refresh: cover property (@(posedge i_clk) g_ch[0].st_q == LSF_REFRESH);
  c_cmd: cover property (@(posedge i_clk) cs_rise);
endmodule : lsf_switch

// ---- test/lsf_host_model.sv ----
// Host serial controller model that frames commands and collects status.
`timescale 1ns/1ps
module lsf_host_model (
  // Serial link toward the switch.
  output logic        o_sclk,
  output logic        o_cs_n,
  output logic        o_si,
  input  wire logic   i_so,
  // Collected status word.
  output logic        o_rx_valid,
  output logic [15:0] o_rx_data
);
  localparam realtime HALF = 80.0;

  initial begin
    o_sclk     = 1'b0;
    o_cs_n     = 1'b1;
    o_si       = 1'b0;
    o_rx_valid = 1'b0;
    o_rx_data  = 16'h0000;
  end

  // ---------------------------------------------------------------
  // Frame
  // ---------------------------------------------------------------
  // Each status bit is taken just before the next clock fall replaces it.
  task automatic xfer(input int n, input logic [15:0] d, input bit chk);
    logic [15:0] rx;
    rx = 16'h0000;
    #(1003.7);
    o_cs_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_si = d[i];
      #(HALF);
      o_sclk = 1'b1;
      #(HALF);
      if (i != n - 1) rx = {rx[14:0], i_so};
      o_sclk = 1'b0;
    end
    #(HALF);
    rx = {rx[14:0], i_so};
    o_cs_n     = 1'b1;
    o_si       = ~o_si;
    o_rx_data  = rx;
    o_rx_valid = chk;
    #1 o_rx_valid = 1'b0;
  endtask : xfer
endmodule : lsf_host_model

// ---- test/lsf_switch_tb.sv ----
// Self-checking bench for the low-side switch serial port and fault timing.
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module lsf_switch_tb;
  import lsf_pkg::*;
  localparam int RETRY = 20, REFRESH = 40, OFF = 10, ON = 30;
  logic               i_clk;
  logic               i_reset_n;
  wire logic          sclk, cs_n, si, so, so_oe, rx_valid;
  wire logic [15:0]   rx_data;
  wire logic          so_line = so_oe ? so : 1'b1;
  lsf_sense_type      sense;
  logic [5:0]         outs, mask;
  logic [15:0]        cmd, exp_w;
  logic [15:0]        exp_q[$];
  int                 n_errors = 0, n_checks = 0, cyc = 0, cnt;
  integer             seed = 32'hd8a462e9;

  lsf_switch #(.RETRY_CYC(RETRY), .REFRESH_CYC(REFRESH), .OFF_CYC(OFF), .ON_CYC(ON)) dut_u (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_si(si),
    .o_so(so), .o_so_oe(so_oe), .i_sense(sense), .o_power_switch_outputs(outs));
  lsf_host_model host_u (
    .o_sclk(sclk), .o_cs_n(cs_n), .o_si(si), .i_so(so_line),
    .o_rx_valid(rx_valid), .o_rx_data(rx_data));

  // ---------------------------------------------------------------
  // Clock, watchdog and status monitor
  // ---------------------------------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      print_verdict();
    end
  end

  always @(posedge rx_valid) begin
    exp_w = exp_q.size() ? exp_q.pop_front() : ~rx_data;
    `CHK(rx_data, exp_w)
  end

  task automatic print_verdict();
    if (n_errors == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : print_verdict

  task automatic clks(input int n);
    repeat (n) @(negedge i_clk);
  endtask : clks

  task automatic frame(input int n, input logic [15:0] d, input bit chk, input logic [5:0] flt);
    if (chk) exp_q.push_back(n == 8 ? {8'h00, 2'b00, flt} : {2'b00, flt, 8'h00});
    host_u.xfer(n, d, chk);
  endtask : frame

  // Counts cycles while the masked outputs hold one level.
  task automatic run_len(input logic [5:0] lvl, output int n);
    n = 0;
    while ((outs & mask) === lvl && n < 300) begin
      clks(1);
      n++;
    end
  endtask : run_len

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    i_reset_n = 1'b0;
    sense     = '0;
    clks(16);
    i_reset_n = 1'b1;
    clks(2);
    `CHK(outs, 6'h00)
    // Random commands of both lengths, each followed by a refused length.
    for (int k = 0; k < 6; k++) begin
      cmd      = 16'($random(seed));
      cmd[7:6] = 2'b00;
      mask     = outs;
      frame((k % 2) ? 16 : 8, cmd, 1'b1, 6'h00);
      clks(2);
      `CHK(outs, mask)
      clks(10);
      `CHK(outs, cmd[5:0])
      frame(12, ~cmd, 1'b0, 6'h00);
      clks(12);
      `CHK(outs, cmd[5:0])
    end
    // A short on the switched-on channels starts the retry cycle.
    mask = 6'($random(seed));
    if (mask == 6'h00) mask = 6'h01;
    frame(8, {10'h000, mask}, 1'b0, 6'h00);
    clks(12);
    sense.short_fault = mask;
    run_len(mask, cnt);
    run_len(6'h00, cnt);
    `CHK(cnt inside {[REFRESH - 2:REFRESH + 4]}, 1'b1)
    run_len(mask, cnt);
    `CHK(cnt inside {[RETRY - 2:RETRY + 4]}, 1'b1)
    frame(8, {10'h000, mask}, 1'b1, mask);
    sense.short_fault = 6'h00;
    clks(REFRESH + RETRY + 20);
    `CHK(outs, mask)
    // Open load seen with the channels off.
    frame(8, 16'h0000, 1'b0, 6'h00);
    clks(12);
    sense.open_fault = mask;
    clks(OFF + 8);
    frame(8, 16'h0000, 1'b1, mask);
    // Open load seen with the channels on, for each enable setting.
    for (int j = 0; j < 4; j++) begin
      frame(8, {8'h00, 2'(j), mask}, 1'b0, 6'h00);
      clks(ON + 8);
      frame(8, {8'h00, 2'(j), mask}, 1'b1, (j != 0) ? mask : 6'h00);
    end
    clks(20);
    print_verdict();
  end
endmodule : lsf_switch_tb
